/* ptmr_top.sv */
// Paired 16/32-bit timer with AXI4-Lite registers.
`timescale 1ns/100ps
module ptmr_top #(
    parameter bit HAS_ADC_TRIG = 1'b1
) (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic [5:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [5:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_dev_idle,
    input  wire logic        i_low_power_rc_osc,
    input  wire logic [1:0]  i_timer_ext_clk_in,
    output logic             o_lower_irq_flag,
    output logic             o_upper_irq_flag,
    output logic             o_adc_trig
);
    logic        wr, wr_ok, rd_ok;
    logic [5:0]  wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0]  wr_strb;
    logic [15:0] ctl_r [2], ctl_nxt [2];
    logic [15:0] per_r [2], per_nxt [2];
    logic [15:0] cnt_r [2], cnt_nxt [2];
    logic [1:0]  flg_r, flg_nxt;
    logic        trig_r, trig_nxt;
    logic [1:0]  tick, en, cwr;
    logic        join_sel;
    logic [31:0] wmask;

    ptmr_axi u_axi (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_wr      (wr),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_wr_strb (wr_strb),
        .i_wr_ok   (wr_ok),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data),
        .i_rd_ok   (rd_ok)
    );

    assign join_sel = ctl_r[0][ptmr_pkg::BIT_JOIN];
    assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // One tick generator per half; in joined mode the upper half reuses the lower controls.
    for (genvar g = 0; g < 2; g++) begin : g_half
        logic [15:0] ctl_use;
        logic        wr_use;
        assign ctl_use = (join_sel && g == 1) ? ctl_r[0] : ctl_r[g];
        assign wr_use  = (join_sel && g == 1) ? cwr[0] : cwr[g];
        assign cwr[g] = wr && (wr_addr == (g == 0 ? ptmr_pkg::OFS_LO_CTRL : ptmr_pkg::OFS_HI_CTRL))
                        && ctl_r[g][ptmr_pkg::BIT_RUN];
        // Run bit with idle stop.
        assign en[g] = ctl_use[ptmr_pkg::BIT_RUN]
                       && !(i_dev_idle && ctl_use[ptmr_pkg::BIT_IDLE_HALT]);
        ptmr_tick u_tick (
            .i_clock   (i_clock),
            .i_sys_rst (i_sys_rst),
            .i_ctrl    (ctl_use),
            .i_ctrl_wr (wr_use),
            .i_enable  (en[g]),
            .i_ext_pin (i_timer_ext_clk_in[join_sel ? 0 : g]),
            .i_lp_osc  (i_low_power_rc_osc),
            .i_gate    (i_timer_ext_clk_in[join_sel ? 0 : g]),
            .o_tick    (tick[g])
        );
    end

    // Address decode for reads; unmapped offsets answer with an error.
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        case (rd_addr)
            ptmr_pkg::OFS_LO_CTRL: rd_data = {16'h0000, ctl_r[0]};
            ptmr_pkg::OFS_HI_CTRL: rd_data = {16'h0000, ctl_r[1]};
            ptmr_pkg::OFS_PER_LO:  rd_data = {16'h0000, per_r[0]};
            ptmr_pkg::OFS_PER_HI:  rd_data = {16'h0000, per_r[1]};
            ptmr_pkg::OFS_CNT_LO:  rd_data = {16'h0000, cnt_r[0]};
            ptmr_pkg::OFS_CNT_HI:  rd_data = {16'h0000, cnt_r[1]};
            ptmr_pkg::OFS_FLAGS:   rd_data = {30'h0, flg_r};
            default:               rd_ok   = 1'b0;
        endcase
        wr_ok = (wr_addr <= ptmr_pkg::OFS_FLAGS) && (wr_addr[1:0] == 2'h0);
    end

    // Counting, match detection, flags and register writes.
    always_comb begin
        logic        m_lo, m_hi, m_32;
        logic [31:0] wv;
        m_lo = 1'b0;
        m_hi = 1'b0;
        m_32 = 1'b0;
        wv   = wr_data & wmask;
        for (int i = 0; i < 2; i++) begin
            ctl_nxt[i] = ctl_r[i];
            per_nxt[i] = per_r[i];
            cnt_nxt[i] = cnt_r[i];
        end
        flg_nxt  = flg_r;
        trig_nxt = 1'b0;
        if (join_sel) begin
            // Lower word carries into upper word; match against both period words.
            m_32 = ({cnt_r[1], cnt_r[0]} == {per_r[1], per_r[0]});
            if (tick[0]) begin
                if (m_32) begin
                    cnt_nxt[0] = 16'h0000;
                    cnt_nxt[1] = 16'h0000;
                    flg_nxt[1] = 1'b1;
                    trig_nxt   = HAS_ADC_TRIG;
                end else begin
                    {cnt_nxt[1], cnt_nxt[0]} = {cnt_r[1], cnt_r[0]} + 32'h00000001;
                end
            end
        end else begin
            // Two independent synchronous 16-bit timers.
            m_lo = (cnt_r[0] == per_r[0]);
            m_hi = (cnt_r[1] == per_r[1]);
            if (tick[0]) begin
                cnt_nxt[0] = m_lo ? 16'h0000 : cnt_r[0] + 16'h0001;
                flg_nxt[0] = flg_r[0] | m_lo;
            end
            if (tick[1]) begin
                cnt_nxt[1] = m_hi ? 16'h0000 : cnt_r[1] + 16'h0001;
                flg_nxt[1] = flg_r[1] | m_hi;
                trig_nxt   = HAS_ADC_TRIG & m_hi;
            end
        end
        if (wr) begin
            case (wr_addr)
                ptmr_pkg::OFS_LO_CTRL: ctl_nxt[0] = wv[15:0] & ptmr_pkg::CTRL_MASK;
                ptmr_pkg::OFS_HI_CTRL: ctl_nxt[1] = wv[15:0] & ptmr_pkg::CTRL_MASK
                                                    & ~(16'h0001 << ptmr_pkg::BIT_JOIN);
                ptmr_pkg::OFS_PER_LO:  per_nxt[0] = wv[15:0];
                ptmr_pkg::OFS_PER_HI:  per_nxt[1] = wv[15:0];
                ptmr_pkg::OFS_CNT_LO:  cnt_nxt[0] = wv[15:0];
                ptmr_pkg::OFS_CNT_HI:  cnt_nxt[1] = wv[15:0];
                // Write one to clear; a flag set in the same cycle wins.
                // Joined mode counts on the lower tick, so that tick sets the upper flag.
                ptmr_pkg::OFS_FLAGS:   flg_nxt = (flg_r & ~wv[1:0])
                                       | {join_sel ? (tick[0] & m_32) : (tick[1] & m_hi),
                                          tick[0] & m_lo};
                default:               ctl_nxt[0] = ctl_r[0];
            endcase
        end
    end

    // Timer state registers.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 2; i++) begin
                ctl_r[i] <= ptmr_pkg::CTRL_RESET;
                per_r[i] <= ptmr_pkg::PERIOD_RESET;
                cnt_r[i] <= ptmr_pkg::COUNT_RESET;
            end
            flg_r  <= 2'h0;
            trig_r <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ctl_r[i] <= ctl_nxt[i];
                per_r[i] <= per_nxt[i];
                cnt_r[i] <= cnt_nxt[i];
            end
            flg_r  <= flg_nxt;
            trig_r <= trig_nxt;
        end
    end

    assign o_lower_irq_flag = flg_r[0];
    assign o_upper_irq_flag = flg_r[1];
    assign o_adc_trig       = trig_r;
endmodule : ptmr_top

/* ptmr_pkg.sv */
// Package with register map, field positions and reset values of the paired timer block.
// Operation
// - A pair runs as two 16-bit timers, one 32-bit timer or 32-bit counter.
// - Split halves keep every 16-bit mode except asynchronous counting.
// - Each 16-bit timer can run alone as synchronous timer or counter.
// - Conversion trigger only on first pair: joined match, or upper half match.
// - Joined mode raises the interrupt when 32-bit count equals 32-bit period.
// - Joined mode: lower timer is low word, upper timer is high word.
// - Joined mode ignores the upper control register; lower control steers all.
// - Joined mode uses lower clock and gate; match flags the upper interrupt.
// - Lower control bit 3 joins the pair when set, splits when clear.
// - Joined period: upper period holds high word, lower period low word.
// - Live count sits in counter pair, upper high word, lower low word.
// - Control bit 15 starts counting when one and stops when zero.
// - Control bit 13 set halts the timer while the device is idle.
// - Source select and gate enable together choose clock and gating mode.
// - Source select clear counts instruction clock; set uses extended select field.
// - External source with extended select low bit set counts the timer pin.
// - Any control write while running resets the prescale counter.
package ptmr_pkg;
    localparam logic [5:0]  OFS_LO_CTRL   = 6'h00;
    localparam logic [5:0]  OFS_HI_CTRL   = 6'h04;
    localparam logic [5:0]  OFS_PER_LO    = 6'h08;
    localparam logic [5:0]  OFS_PER_HI    = 6'h0C;
    localparam logic [5:0]  OFS_CNT_LO    = 6'h10;
    localparam logic [5:0]  OFS_CNT_HI    = 6'h14;
    localparam logic [5:0]  OFS_FLAGS     = 6'h18;
    localparam int          BIT_RUN       = 15;
    localparam int          BIT_IDLE_HALT = 13;
    localparam int          BIT_EXT_HI    = 9;
    localparam int          BIT_EXT_LO    = 8;
    localparam int          BIT_GATE      = 6;
    localparam int          BIT_PRE_HI    = 5;
    localparam int          BIT_PRE_LO    = 4;
    localparam int          BIT_JOIN      = 3;
    localparam int          BIT_SRC       = 1;
    localparam logic [15:0] CTRL_MASK     = 16'hA37A;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ptmr_pkg

/* ptmr_tick.sv */
// Count clock selection, gating and prescaler for one timer.
`timescale 1ns/100ps
module ptmr_tick (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic [15:0] i_ctrl,
    input  wire logic       i_ctrl_wr,
    input  wire logic       i_enable,
    input  wire logic       i_ext_pin,
    input  wire logic       i_lp_osc,
    input  wire logic       i_gate,
    output logic            o_tick
);
    logic [7:0] pre_r, pre_nxt;
    logic       pin_d_r, pin_d_nxt, lp_d_r, lp_d_nxt;
    logic       src_edge, raw, pre_hit;
    logic [7:0] pre_top;

    // Source choice: instruction-clock enable is every cycle, or the gate level when gated; external inputs count rising edges.
    always_comb begin
        src_edge = i_ctrl[ptmr_pkg::BIT_EXT_LO] ? (i_ext_pin & ~pin_d_r)
                 : i_ctrl[ptmr_pkg::BIT_EXT_HI] ? (i_lp_osc & ~lp_d_r) : 1'b0;
        if (!i_ctrl[ptmr_pkg::BIT_SRC]) begin
            raw = i_ctrl[ptmr_pkg::BIT_GATE] ? i_gate : 1'b1;
        end else begin
            raw = src_edge;
        end
        case (i_ctrl[ptmr_pkg::BIT_PRE_HI:ptmr_pkg::BIT_PRE_LO])
            2'h0:    pre_top = 8'h00;
            2'h1:    pre_top = 8'h07;
            2'h2:    pre_top = 8'h3F;
            default: pre_top = 8'hFF;
        endcase
        pre_hit = raw & (pre_r >= pre_top);
        pre_nxt = pre_r;
        if (i_ctrl_wr || !i_enable) begin
            pre_nxt = 8'h00;
        end else if (raw) begin
            pre_nxt = pre_hit ? 8'h00 : pre_r + 8'h01;
        end
        pin_d_nxt = i_ext_pin;
        lp_d_nxt  = i_lp_osc;
        o_tick    = pre_hit & i_enable & ~i_ctrl_wr;
    end

    // Prescale count and edge history.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pre_r   <= 8'h00;
            pin_d_r <= 1'b0;
            lp_d_r  <= 1'b0;
        end else begin
            pre_r   <= pre_nxt;
            pin_d_r <= pin_d_nxt;
            lp_d_r  <= lp_d_nxt;
        end
    end
endmodule : ptmr_tick

/* ptmr_axi.sv */
// AXI4-Lite slave front end giving a one-cycle register write strobe and a direct read address.
`timescale 1ns/100ps
module ptmr_axi (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic [5:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [5:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic             o_wr,
    output logic [5:0]       o_wr_addr,
    output logic [31:0]      o_wr_data,
    output logic [3:0]       o_wr_strb,
    input  wire logic        i_wr_ok,
    output logic [5:0]       o_rd_addr,
    input  wire logic [31:0] i_rd_data,
    input  wire logic        i_rd_ok
);
    logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
    logic [5:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;

    // Address and data are latched independently, so either may arrive first.
    always_comb begin
        o_awready = ~aw_r & ~b_r;
        o_wready  = ~w_r & ~b_r;
        o_arready = ~r_r;
        aw_nxt = aw_r;
        w_nxt  = w_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        if (i_awvalid && o_awready) begin
            aw_nxt  = 1'b1;
            awa_nxt = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            w_nxt  = 1'b1;
            wd_nxt = i_wdata;
            ws_nxt = i_wstrb;
        end
        o_wr      = aw_r & w_r;
        o_wr_addr = awa_r;
        o_wr_data = wd_r;
        o_wr_strb = ws_r;
        b_nxt  = b_r;
        br_nxt = br_r;
        if (o_wr) begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            b_nxt  = 1'b1;
            br_nxt = i_wr_ok ? ptmr_pkg::RESP_OKAY : ptmr_pkg::RESP_SLVERR;
        end else if (b_r && i_bready) begin
            b_nxt = 1'b0;
        end
        o_rd_addr = i_araddr;
        r_nxt  = r_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (i_arvalid && o_arready) begin
            r_nxt  = 1'b1;
            rd_nxt = i_rd_data;
            rr_nxt = i_rd_ok ? ptmr_pkg::RESP_OKAY : ptmr_pkg::RESP_SLVERR;
        end else if (r_r && i_rready) begin
            r_nxt = 1'b0;
        end
        o_bvalid = b_r;
        o_bresp  = br_r;
        o_rvalid = r_r;
        o_rdata  = rd_r;
        o_rresp  = rr_r;
    end

    // Channel state registers.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aw_r  <= 1'b0;
            w_r   <= 1'b0;
            b_r   <= 1'b0;
            r_r   <= 1'b0;
            awa_r <= 6'h00;
            wd_r  <= 32'h00000000;
            ws_r  <= 4'h0;
            br_r  <= 2'h0;
            rd_r  <= 32'h00000000;
            rr_r  <= 2'h0;
        end else begin
            aw_r  <= aw_nxt;
            w_r   <= w_nxt;
            b_r   <= b_nxt;
            r_r   <= r_nxt;
            awa_r <= awa_nxt;
            wd_r  <= wd_nxt;
            ws_r  <= ws_nxt;
            br_r  <= br_nxt;
            rd_r  <= rd_nxt;
            rr_r  <= rr_nxt;
        end
    end
endmodule : ptmr_axi

/* ptmr_ext_src.sv */
// Model of the routed timer pins and the low-power oscillator.
`timescale 1ns/100ps
module ptmr_ext_src #(
    parameter int HALF = 3
) (
    input  wire logic       i_clock,
    input  wire logic       i_go,
    output logic [1:0]      o_pin,
    output logic            o_lp
);
    int   cnt_r;
    int   lp_r;
    // Pins toggle only while a burst is on; otherwise they stand still low.
    always @(posedge i_clock) begin
        cnt_r <= (cnt_r >= HALF - 1) ? 0 : cnt_r + 1;
        if (!i_go) begin
            o_pin <= 2'h0;
        end else if (cnt_r == 0) begin
            o_pin <= ~o_pin;
        end
    end
    // The oscillator runs free, slower than the pins.
    always @(posedge i_clock) begin
        lp_r <= (lp_r >= 2 * HALF) ? 0 : lp_r + 1;
        if (lp_r == 0) begin
            o_lp <= ~o_lp;
        end
    end
    initial begin
        o_pin = 2'h0;
        o_lp  = 1'b0;
        cnt_r = 0;
        lp_r  = 0;
    end
endmodule : ptmr_ext_src

/* ptmr_top_assertions.sv */
// Concurrent checks on the ports of the paired timer.
`timescale 1ns/100ps
module ptmr_top_chk (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_awvalid,
    input  wire logic        o_awready,
    input  wire logic        i_wvalid,
    input  wire logic        o_wready,
    input  wire logic [1:0]  o_bresp,
    input  wire logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [5:0]  i_araddr,
    input  wire logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire logic [31:0] o_rdata,
    input  wire logic [1:0]  o_rresp,
    input  wire logic        o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        o_lower_irq_flag,
    input  wire logic        o_upper_irq_flag,
    input  wire logic        o_adc_trig
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // A write is taken when both channels meet; the answer comes two edges on.
    sequence s_wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_resp;
        !o_bvalid ##1 o_bvalid;
    endsequence
    a_write_resp_time: assert property (s_wr_take |=> s_resp)
        else $error("write response late or early");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before taken");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before taken");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer missing");
    a_read_slverr: assert property (i_arvalid && o_arready
        && (i_araddr > 6'h18 || i_araddr[1:0] != 2'h0) |=> o_rresp == ptmr_pkg::RESP_SLVERR)
        else $error("bad read address not refused");
    a_aw_block: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("new write taken while response pending");
    a_aw_reopen: assert property (o_bvalid && i_bready |=> o_awready && o_wready)
        else $error("write channels not reopened");
    a_trig_pulse: assert property (o_adc_trig |=> !o_adc_trig)
        else $error("trigger longer than one cycle");
    a_trig_flag: assert property (o_adc_trig |-> o_upper_irq_flag)
        else $error("trigger without upper match flag");
    a_flag_clear: assert property ($fell(o_upper_irq_flag) || $fell(o_lower_irq_flag)
        |-> o_bvalid)
        else $error("match flag cleared without a write");
endmodule : ptmr_top_chk

/* test_paired_timer_16_32.sv */
// Self-checking bench of the paired timer over AXI4-Lite.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t mismatch %h %h", $time, (a), (b)); end end
module test_paired_timer_16_32;
    logic        i_clock, i_sys_rst, awv, wv, br, arv, rr, idle, go, trig_seen;
    logic [5:0]  aw, ar;
    logic [31:0] wd;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [1:0]  pin;
    logic        lp;
    int          err_count, check_count, cyc, n, p;
    wire logic        awrdy, wrdy, bv, arrdy, rv, lo_f, up_f, trig;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rd_w;
    ptmr_top u_ptmr_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_awaddr(aw),
        .i_awvalid(awv), .o_awready(awrdy), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ar),
        .i_arvalid(arv), .o_arready(arrdy), .o_rdata(rd_w), .o_rresp(rresp), .o_rvalid(rv),
        .i_rready(rr), .i_dev_idle(idle), .i_low_power_rc_osc(lp), .i_timer_ext_clk_in(pin),
        .o_lower_irq_flag(lo_f), .o_upper_irq_flag(up_f), .o_adc_trig(trig));
    ptmr_ext_src u_ptmr_ext_src (.i_clock(i_clock), .i_go(go), .o_pin(pin), .o_lp(lp));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // Watchdog; the whole run needs well under this many cycles.
    always @(posedge i_clock) begin
        cyc++;
        if (trig === 1'b1) trig_seen <= 1'b1;
        if (cyc == 40000) begin err_count++; complete_run(); end
    end
    task automatic complete_run();
        $display("Errors %0d of %0d checks", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clock);
        aw <= a; wd <= {16'h0000, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv === 1'b1) begin resp = bresp; br <= 1'b0; break; end
        end
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge i_clock);
        ar <= a; arv <= 1'b1; rr <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (arv && arrdy) arv <= 1'b0;
            if (rv === 1'b1) begin rdata = rd_w; resp = rresp; rr <= 1'b0; break; end
        end
    endtask : rd
    task automatic wait_flag(input bit up);
        n = 0;
        while ((up ? up_f : lo_f) !== 1'b1 && n < 3000) begin @(posedge i_clock); n++; end
    endtask : wait_flag
    // A match needs period plus one prescaled ticks; a little slack covers the write path.
    function automatic bit in_time(int c, int per, int k);
        int d;
        d = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
        return n >= (per + 1) * d * k - d && n <= (per + 1) * d * k + 6 * k;
    endfunction : in_time
    task automatic go_sleep(input int k);
        repeat (k) @(posedge i_clock);
    endtask : go_sleep
    initial begin
        {i_sys_rst, awv, wv, br, arv, rr, idle, go, trig_seen} = 9'h100;
        {aw, ar, wd, err_count, check_count, cyc} = '0;
        void'($urandom(65420));
        go_sleep(16);
        i_sys_rst <= 1'b0;
        rd(ptmr_pkg::OFS_LO_CTRL); `CHK(rdata, 32'h00000000)
        rd(ptmr_pkg::OFS_PER_LO);  `CHK(rdata[15:0], ptmr_pkg::PERIOD_RESET)
        rd(6'h1C); `CHK(resp, ptmr_pkg::RESP_SLVERR)
        wr(6'h02, 16'h0000); `CHK(resp, ptmr_pkg::RESP_SLVERR)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h7FFF); rd(ptmr_pkg::OFS_LO_CTRL);
        `CHK(rdata[15:0], 16'h237A)
        wr(ptmr_pkg::OFS_HI_CTRL, 16'h7FFF); rd(ptmr_pkg::OFS_HI_CTRL);
        `CHK(rdata[15:0], 16'h2372)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h0000); wr(ptmr_pkg::OFS_HI_CTRL, 16'h0000);
        // Upper half alone through every prescale code; only it may trigger.
        wr(ptmr_pkg::OFS_PER_HI, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            wr(ptmr_pkg::OFS_CNT_HI, 16'h0000); wr(ptmr_pkg::OFS_FLAGS, 16'h0003);
            trig_seen <= 1'b0;
            wr(ptmr_pkg::OFS_HI_CTRL, 16'h8000 | 16'(c << 4)); wait_flag(1'b1);
            `CHK(in_time(c, 3, 1), 1'b1)
            go_sleep(2); `CHK(trig_seen, 1'b1)
            `CHK(lo_f, 1'b0)
            wr(ptmr_pkg::OFS_HI_CTRL, 16'h0000);
        end
        // Lower half with random periods; it has no trigger.
        for (int i = 0; i < 3; i++) begin
            p = $urandom_range(40, 2);
            wr(ptmr_pkg::OFS_PER_LO, 16'(p)); wr(ptmr_pkg::OFS_CNT_LO, 16'h0000);
            wr(ptmr_pkg::OFS_FLAGS, 16'h0003); trig_seen <= 1'b0;
            wr(ptmr_pkg::OFS_LO_CTRL, 16'h8000); wait_flag(1'b0);
            `CHK(in_time(0, p, 1), 1'b1)
            `CHK(trig_seen, 1'b0)
            wr(ptmr_pkg::OFS_LO_CTRL, 16'h0000);
        end
        // Joined pair: carry across the words, upper control ignored, upper flag used.
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h0008); wr(ptmr_pkg::OFS_HI_CTRL, 16'h8030);
        wr(ptmr_pkg::OFS_CNT_LO, 16'hFFF0); wr(ptmr_pkg::OFS_CNT_HI, 16'h0000);
        wr(ptmr_pkg::OFS_PER_LO, 16'h0005); wr(ptmr_pkg::OFS_PER_HI, 16'h0001);
        wr(ptmr_pkg::OFS_FLAGS, 16'h0003); trig_seen <= 1'b0;
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h8008); wait_flag(1'b1);
        `CHK(in_time(0, 21, 1), 1'b1)
        go_sleep(2); `CHK(lo_f, 1'b0)
        `CHK(trig_seen, 1'b1)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h0008); rd(ptmr_pkg::OFS_CNT_HI);
        `CHK(rdata[15:0], 16'h0000)
        wr(ptmr_pkg::OFS_HI_CTRL, 16'h0000); wr(ptmr_pkg::OFS_LO_CTRL, 16'h0000);
        // Pin as count clock; each tick takes two toggles of three cycles.
        wr(ptmr_pkg::OFS_PER_LO, 16'h0003); wr(ptmr_pkg::OFS_CNT_LO, 16'h0000);
        wr(ptmr_pkg::OFS_FLAGS, 16'h0003); wr(ptmr_pkg::OFS_LO_CTRL, 16'h8102);
        go <= 1'b1; wait_flag(1'b0); go <= 1'b0;
        `CHK(n inside {[18 : 30]}, 1'b1)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h0000); wr(ptmr_pkg::OFS_CNT_LO, 16'h0000);
        wr(ptmr_pkg::OFS_PER_LO, 16'hFFFF);
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h8002); go <= 1'b1; go_sleep(60); go <= 1'b0;
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0], 16'h0000)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h8040); go_sleep(60);
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0], 16'h0000)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h8202); go_sleep(60);
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0] != 16'h0000, 1'b1)
        p = rdata[15:0]; wr(ptmr_pkg::OFS_LO_CTRL, 16'h8040); go <= 1'b1; go_sleep(60);
        go <= 1'b0; rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0] >= 16'(p + 20), 1'b1)
        // Idle halt stops counting while the device idles; with the halt bit clear it counts even when idle.
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h0000); wr(ptmr_pkg::OFS_CNT_LO, 16'h0000);
        idle <= 1'b1; wr(ptmr_pkg::OFS_LO_CTRL, 16'hA000); go_sleep(40);
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0], 16'h0000)
        wr(ptmr_pkg::OFS_LO_CTRL, 16'h8000); go_sleep(10);
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0] != 16'h0000, 1'b1)
        idle <= 1'b0;
        wr(ptmr_pkg::OFS_FLAGS, 16'h0003); rd(ptmr_pkg::OFS_FLAGS);
        `CHK(rdata[1:0], 2'h0)
        // Reset in mid-run clears control and count.
        @(posedge i_clock); i_sys_rst <= 1'b1; go_sleep(2); i_sys_rst <= 1'b0;
        rd(ptmr_pkg::OFS_LO_CTRL); `CHK(rdata[15:0], ptmr_pkg::CTRL_RESET)
        rd(ptmr_pkg::OFS_CNT_LO); `CHK(rdata[15:0], ptmr_pkg::COUNT_RESET)
        complete_run();
    end
endmodule : test_paired_timer_16_32
bind ptmr_top ptmr_top_chk u_ptmr_top_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_lower_irq_flag(o_lower_irq_flag),
    .o_upper_irq_flag(o_upper_irq_flag), .o_adc_trig(o_adc_trig));
